// ==== pcx_pkg.sv ====
// Purpose: Shared constants and carriers for the port crossbar.
// Assumes: 21 pins, port 0 pins 0-7, port 1 pins 8-15, port 2 pins 16-20.
// Notes: Resource indices give crossbar priority, lowest index first.
package pcx_pkg;
  // ==========================================================================
  // Sizes
  localparam int PIN_COUNT = 21;
  localparam int RES_COUNT = 17;
  localparam int RES_W = 5;
  // ==========================================================================
  // Resource indices in priority order
  localparam logic [RES_W-1:0] RES_UART_TX = 5'h00;
  localparam logic [RES_W-1:0] RES_UART_RX = 5'h01;
  localparam logic [RES_W-1:0] RES_SPI_SCK = 5'h02;
  localparam logic [RES_W-1:0] RES_SPI_MISO = 5'h03;
  localparam logic [RES_W-1:0] RES_SPI_MOSI = 5'h04;
  localparam logic [RES_W-1:0] RES_SPI_SEL = 5'h05;
  localparam logic [RES_W-1:0] RES_TW_DATA = 5'h06;
  localparam logic [RES_W-1:0] RES_TW_CLOCK = 5'h07;
  localparam logic [RES_W-1:0] RES_CMP_SYNC = 5'h08;
  localparam logic [RES_W-1:0] RES_CMP_ASYNC = 5'h09;
  localparam logic [RES_W-1:0] RES_CORE_CLK = 5'h0a;
  localparam logic [RES_W-1:0] RES_CNT_CH0 = 5'h0b;
  localparam logic [RES_W-1:0] RES_CNT_CH1 = 5'h0c;
  localparam logic [RES_W-1:0] RES_CNT_CH2 = 5'h0d;
  localparam logic [RES_W-1:0] RES_EXT_CNT = 5'h0e;
  localparam logic [RES_W-1:0] RES_TIMER_A = 5'h0f;
  localparam logic [RES_W-1:0] RES_TIMER_B = 5'h10;
  localparam int RES_FIRST_FREE = 2;
  // ==========================================================================
  // Pin positions
  localparam int PIN_UART_TX = 4;
  localparam int PIN_UART_RX = 5;
  localparam int PIN_P2_0 = 16;
  localparam int PIN_P2_1 = 17;
  localparam int PIN_P2_4 = 20;
  // ==========================================================================
  // Reset values and counter route field codes
  localparam logic [PIN_COUNT-1:0] SKIP_RST = 21'h000000;
  localparam logic [PIN_COUNT-1:0] INPUT_MODE_RST = 21'h1fffff;
  localparam logic [PIN_COUNT-1:0] OUTPUT_MODE_RST = 21'h000000;
  localparam logic [PIN_COUNT-1:0] GPIO_LATCH_RST = 21'h1fffff;
  localparam logic [RES_COUNT-1:0] PERIPH_IN_RST = 17'h1ffff;
  localparam logic [1:0] CNT_ROUTE_NONE = 2'h0;
  localparam logic [1:0] CNT_ROUTE_CH01 = 2'h2;
  localparam logic [1:0] CNT_ROUTE_CH012 = 2'h3;
  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic comparator_async_out;
    logic comparator_sync_out;
    logic core_clock_output;
    logic two_wire;
    logic spi;
    logic uart;
  } pcx_route_a_t;
  typedef struct packed {
    logic pullup_disable;
    logic routing_global_enable;
    logic timer_b_input;
    logic timer_a_input;
    logic external_count_input;
    logic [1:0] counter_channel_route_field;
  } pcx_route_b_t;
  typedef struct packed {
    logic [PIN_COUNT-1:0] pin_skip_mask;
    logic [PIN_COUNT-1:0] pin_input_mode;
    logic [PIN_COUNT-1:0] pin_output_mode;
  } pcx_pin_cfg_t;
  typedef struct packed {
    logic [RES_COUNT-1:0] val;
    logic [RES_COUNT-1:0] en;
  } pcx_periph_t;
endpackage : pcx_pkg

// ==== pcx_pin_cell.sv ====
// Purpose: One port pin: driver, weak pull-up and input receiver.
// Assumes: Inputs other than i_pin_in come from logic on i_clock.
// Notes: All outputs are registered.
`timescale 1ns/1ps
module pcx_pin_cell (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_drive_val,
  input wire logic i_drive_en,
  input wire logic i_push_pull,
  input wire logic i_digital,
  input wire logic i_pullup_dis,
  input wire logic i_pin_in,
  output logic o_pin_out,
  output logic o_pin_oe,
  output logic o_pullup_en,
  output logic o_level
);
  // ==========================================================================
  // State
  logic sync_a_reg; // First synchroniser stage
  logic sync_b_reg; // Second synchroniser stage
  logic out_reg, out_next;
  logic oe_reg, oe_next;
  logic pu_reg, pu_next;
  logic lvl_reg, lvl_next;

  // Next driver, pull-up and receiver values
  always_comb begin
    out_next = 1'b0;
    oe_next = 1'b0;
    lvl_next = 1'b0;
    if (!i_digital) begin
      // Analog: driver, receiver and pull-up all off
      oe_next = 1'b0;
      lvl_next = 1'b0;
    end else if (i_push_pull) begin
      // Push-pull drives both levels
      out_next = i_drive_val;
      oe_next = i_drive_en;
      lvl_next = sync_b_reg;
    end else begin
      // Open-drain only sinks
      out_next = 1'b0;
      oe_next = i_drive_en & ~i_drive_val;
      lvl_next = sync_b_reg;
    end
    // Pull-up on open-drain only, off while driving low
    pu_next = i_digital & ~i_push_pull & ~i_pullup_dis & ~oe_next;
  end

  // Register stage
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      sync_a_reg <= 1'b0;
      sync_b_reg <= 1'b0;
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
      pu_reg <= 1'b0;
      lvl_reg <= 1'b0;
    end else begin
      sync_a_reg <= i_pin_in;
      sync_b_reg <= sync_a_reg;
      out_reg <= out_next;
      oe_reg <= oe_next;
      pu_reg <= pu_next;
      lvl_reg <= lvl_next;
    end
  end

  assign o_pin_out = out_reg;
  assign o_pin_oe = oe_reg;
  assign o_pullup_en = pu_reg;
  assign o_level = lvl_reg;
endmodule : pcx_pin_cell

// ==== pcx_port_crossbar.sv ====
// Purpose: Priority crossbar from peripherals to port pins with pin modes.
// Assumes: Config and peripheral inputs on i_clock; pin inputs asynchronous.
// Notes: Config is registered, allocation is registered, then pin cells.
//   A change to the grants reaches the pin drivers two edges after capture, a mode change one.
//   Pad levels reach o_pin_level and o_periph_in four edges after a change.
//   Pins 4 and 5 carry the UART while it is on, even when skipped.
//   The top port 2 pin never takes a crossbar resource.
//   Resources without a pin read a high level.
//   Routing off clears every grant and every driver.
`timescale 1ns/1ps
module pcx_port_crossbar (
  input wire logic i_clock,
  input wire logic i_rstn,
  input pcx_pkg::pcx_route_a_t i_route_a,
  input pcx_pkg::pcx_route_b_t i_route_b,
  input wire logic i_spi_four_wire,
  input wire logic i_package_24pin,
  input pcx_pkg::pcx_pin_cfg_t i_pin_cfg,
  input wire logic [pcx_pkg::PIN_COUNT-1:0] i_gpio_latch,
  input pcx_pkg::pcx_periph_t i_periph_drive,
  input wire logic [pcx_pkg::PIN_COUNT-1:0] i_pin_in,
  output logic [pcx_pkg::PIN_COUNT-1:0] o_pin_out,
  output logic [pcx_pkg::PIN_COUNT-1:0] o_pin_oe,
  output logic [pcx_pkg::PIN_COUNT-1:0] o_pullup_en,
  output logic [pcx_pkg::PIN_COUNT-1:0] o_pin_level,
  output logic [pcx_pkg::PIN_COUNT-1:0] o_pin_routed,
  output logic [pcx_pkg::RES_COUNT-1:0] o_periph_in
);
  import pcx_pkg::*;

  // ==========================================================================
  // Configuration registers
  pcx_route_a_t route_a_reg, route_a_next; // Resource enables, group a
  pcx_route_b_t route_b_reg, route_b_next; // Resource enables, group b
  pcx_pin_cfg_t pin_cfg_reg, pin_cfg_next; // Skip and mode masks
  logic four_wire_reg, four_wire_next; // Slave select mode
  logic pkg24_reg, pkg24_next; // Package variant

  // Capture configuration each cycle
  // No write strobe: the block samples levels every edge
  always_comb begin
    route_a_next = i_route_a;
    route_b_next = i_route_b;
    pin_cfg_next = i_pin_cfg;
    four_wire_next = i_spi_four_wire;
    pkg24_next = i_package_24pin;
  end

  // Configuration register stage
  // Config comes from logic on this clock, so no synchroniser
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      route_a_reg <= '0;
      route_b_reg <= '0;
      // Reset: digital open-drain inputs, nothing routed
      pin_cfg_reg.pin_skip_mask <= SKIP_RST;
      pin_cfg_reg.pin_input_mode <= INPUT_MODE_RST;
      pin_cfg_reg.pin_output_mode <= OUTPUT_MODE_RST;
      four_wire_reg <= 1'b0;
      pkg24_reg <= 1'b0;
    end else begin
      // Follow the inputs one edge late
      route_a_reg <= route_a_next;
      route_b_reg <= route_b_next;
      pin_cfg_reg <= pin_cfg_next;
      four_wire_reg <= four_wire_next;
      pkg24_reg <= pkg24_next;
    end
  end

  // ==========================================================================
  // Resource requests
  logic [RES_COUNT-1:0] request; // Enabled resources, by priority
  logic [PIN_COUNT-1:0] blocked; // Pins the crossbar must pass over

  // Expand enables into per-signal requests
  // A resource that is off never enters the walk
  always_comb begin
    request = '0;
    // UART pair
    request[RES_UART_TX] = route_a_reg.uart;
    request[RES_UART_RX] = route_a_reg.uart;
    // SPI takes three pins, a fourth for slave select
    request[RES_SPI_SCK] = route_a_reg.spi;
    request[RES_SPI_MISO] = route_a_reg.spi;
    request[RES_SPI_MOSI] = route_a_reg.spi;
    request[RES_SPI_SEL] = route_a_reg.spi & four_wire_reg;
    // Two-wire pair always together
    request[RES_TW_DATA] = route_a_reg.two_wire;
    request[RES_TW_CLOCK] = route_a_reg.two_wire;
    // Single-pin outputs
    request[RES_CMP_SYNC] = route_a_reg.comparator_sync_out;
    request[RES_CMP_ASYNC] = route_a_reg.comparator_async_out;
    request[RES_CORE_CLK] = route_a_reg.core_clock_output;
    // Counter channels join in order 0, 1, 2
    request[RES_CNT_CH0] = route_b_reg.counter_channel_route_field != CNT_ROUTE_NONE;
    request[RES_CNT_CH1] = route_b_reg.counter_channel_route_field >= CNT_ROUTE_CH01;
    request[RES_CNT_CH2] = route_b_reg.counter_channel_route_field == CNT_ROUTE_CH012;
    // Counter and timer inputs last
    request[RES_EXT_CNT] = route_b_reg.external_count_input;
    request[RES_TIMER_A] = route_b_reg.timer_a_input;
    request[RES_TIMER_B] = route_b_reg.timer_b_input;
  end

  // Pins unavailable to the priority walk
  // Skip mask first, then fixed and absent pins on top
  always_comb begin
    blocked = pin_cfg_reg.pin_skip_mask;
    // Fixed UART pins are out of the walk
    if (route_a_reg.uart) begin
      blocked[PIN_UART_TX] = 1'b1;
      blocked[PIN_UART_RX] = 1'b1;
    end
    // Small package: port 2 pins absent or reserved
    if (!pkg24_reg) begin
      blocked[PIN_P2_0] = 1'b1;
      blocked[PIN_P2_4:PIN_P2_1] = 4'hf;
    end
    blocked[PIN_P2_4] = 1'b1; // Never on the crossbar
  end

  // ==========================================================================
  // Priority allocation
  logic [PIN_COUNT-1:0] hit_reg, hit_next; // Pin carries a resource
  logic [RES_W-1:0] sel_reg [PIN_COUNT]; // Resource on each pin
  logic [RES_W-1:0] sel_next [PIN_COUNT];
  logic [RES_COUNT-1:0] pending; // Requests still without a pin
  logic [RES_W-1:0] pick; // Lowest pending resource

  // Walk pins upward, granting the lowest pending resource
  // The walk is one combinational pass over all pins, so a
  // config change costs a single extra edge, not one per pin.
  // Requests beyond the last free pin stay pending and are
  // dropped silently; their inputs then read high.
  always_comb begin
    pending = request;
    pending[RES_UART_TX] = 1'b0;
    pending[RES_UART_RX] = 1'b0;
    // Start with nothing granted
    pick = '0;
    hit_next = '0;
    for (int p = 0; p < PIN_COUNT; p++) begin
      sel_next[p] = '0;
    end
    // UART placed first on its fixed pins
    if (route_a_reg.uart) begin
      hit_next[PIN_UART_TX] = 1'b1;
      sel_next[PIN_UART_TX] = RES_UART_TX;
      hit_next[PIN_UART_RX] = 1'b1;
      sel_next[PIN_UART_RX] = RES_UART_RX;
    end
    for (int p = 0; p < PIN_COUNT; p++) begin
      // Skipped and reserved pins are passed over
      if (!blocked[p] && (pending != '0)) begin
        // Downward scan leaves the lowest index, the highest priority
        for (int r = RES_COUNT - 1; r >= RES_FIRST_FREE; r--) begin
          if (pending[r]) begin
            pick = RES_W'(r);
          end
        end
        // Grant the pin and retire the resource
        hit_next[p] = 1'b1;
        sel_next[p] = pick;
        pending[pick] = 1'b0;
      end
    end
    // Disabled routing leaves every pin a plain input
    if (!route_b_reg.routing_global_enable) begin
      hit_next = '0;
    end
  end

  // Allocation register stage
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      // Nothing routed after reset
      hit_reg <= '0;
      // Select values mean nothing while the grant is low
      for (int p = 0; p < PIN_COUNT; p++) begin
        sel_reg[p] <= '0;
      end
    end else begin
      // Grants follow the config by one edge
      hit_reg <= hit_next;
      for (int p = 0; p < PIN_COUNT; p++) begin
        sel_reg[p] <= sel_next[p];
      end
    end
  end

  // ==========================================================================
  // Pin drive selection and pin cells
  logic [PIN_COUNT-1:0] drv_val; // Level the pin should present
  logic [PIN_COUNT-1:0] drv_en; // Pin should drive
  logic [PIN_COUNT-1:0] push_pull; // Effective output mode
  logic [PIN_COUNT-1:0] level; // Received pin level
  logic [PIN_COUNT-1:0] routed_reg; // Routed flags to outside

  // Per-pin drive choice, one copy per pin
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : gen_pin
      // Choose resource, general purpose or idle drive
      // Idle drive: high level, driver off
      always_comb begin
        drv_val[g] = 1'b1;
        drv_en[g] = 1'b0;
        push_pull[g] = pin_cfg_reg.pin_output_mode[g];
        if (!route_b_reg.routing_global_enable) begin
          // Routing off: pins stay inputs, latch ignored
          drv_en[g] = 1'b0;
        end else if (hit_reg[g]) begin
          // Routed resource drive
          drv_val[g] = i_periph_drive.val[sel_reg[g]];
          drv_en[g] = i_periph_drive.en[sel_reg[g]];
          if ((sel_reg[g] == RES_TW_DATA) || (sel_reg[g] == RES_TW_CLOCK)) begin
            // Two-wire pins never push high
            push_pull[g] = 1'b0;
          end
        end else begin
          // General purpose output from the port latch
          drv_val[g] = i_gpio_latch[g];
          drv_en[g] = 1'b1;
        end
      end

      // One cell per pin: driver, pull-up, three-flop receiver
      pcx_pin_cell u_cell (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_drive_val(drv_val[g]),
        .i_drive_en(drv_en[g]),
        .i_push_pull(push_pull[g]),
        .i_digital(pin_cfg_reg.pin_input_mode[g]),
        .i_pullup_dis(route_b_reg.pullup_disable),
        .i_pin_in(i_pin_in[g]),
        .o_pin_out(o_pin_out[g]),
        .o_pin_oe(o_pin_oe[g]),
        .o_pullup_en(o_pullup_en[g]),
        .o_level(level[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Peripheral inputs
  logic [RES_COUNT-1:0] periph_in_reg, periph_in_next; // Levels back to peripherals
  logic [PIN_COUNT-1:0] level_reg, level_next; // Port read levels
  logic [PIN_COUNT-1:0] routed_next; // Routed flags, next value

  // Route each pin's received level to its resource
  // A pin that is not routed leaves its resource reading high
  always_comb begin
    level_next = level;
    routed_next = hit_reg;
    periph_in_next = PERIPH_IN_RST;
    for (int p = 0; p < PIN_COUNT; p++) begin
      if (hit_reg[p]) begin
        periph_in_next[sel_reg[p]] = level[p];
      end
    end
  end

  // Output register stage
  // All top outputs leave from flip-flops
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      periph_in_reg <= PERIPH_IN_RST;
      level_reg <= '0;
      routed_reg <= '0;
    end else begin
      periph_in_reg <= periph_in_next;
      level_reg <= level_next;
      routed_reg <= routed_next;
    end
  end

  assign o_periph_in = periph_in_reg;
  assign o_pin_level = level_reg;
  assign o_pin_routed = routed_reg;
endmodule : pcx_port_crossbar

// ==== pcx_port_crossbar_assertions.sv ====
// Purpose: Port-level checks on the crossbar.
// Assumes: One clock, synchronous active-low reset.
// Notes: Most checks wait for config steady over the pipe.
`timescale 1ns/1ps
module pcx_port_crossbar_assertions (
  input wire logic i_clock,
  input wire logic i_rstn,
  input pcx_pkg::pcx_route_a_t i_route_a,
  input pcx_pkg::pcx_route_b_t i_route_b,
  input wire logic i_spi_four_wire,
  input wire logic i_package_24pin,
  input pcx_pkg::pcx_pin_cfg_t i_pin_cfg,
  input wire logic [pcx_pkg::PIN_COUNT-1:0] i_gpio_latch,
  input pcx_pkg::pcx_periph_t i_periph_drive,
  input wire logic [pcx_pkg::PIN_COUNT-1:0] i_pin_in,
  input wire logic [pcx_pkg::PIN_COUNT-1:0] o_pin_out,
  input wire logic [pcx_pkg::PIN_COUNT-1:0] o_pin_oe,
  input wire logic [pcx_pkg::PIN_COUNT-1:0] o_pullup_en,
  input wire logic [pcx_pkg::PIN_COUNT-1:0] o_pin_level,
  input wire logic [pcx_pkg::PIN_COUNT-1:0] o_pin_routed,
  input wire logic [pcx_pkg::RES_COUNT-1:0] o_periph_in
);
  import pcx_pkg::*;
  // ==========================================
  // Settle tracking
  logic [77:0] cfg_now; // All config inputs
  logic [77:0] cfg_reg; // Config one edge ago
  logic [2:0] calm_reg; // Edges with config unchanged
  logic quiet; // Config steady over the pipe
  assign cfg_now = {i_route_a, i_route_b, i_spi_four_wire, i_package_24pin, i_pin_cfg};
  assign quiet = calm_reg >= 3'h3 && cfg_now == cfg_reg;
  // Count steady edges, restart on change or reset
  always_ff @(posedge i_clock) begin
    cfg_reg <= cfg_now;
    if (!i_rstn || cfg_now != cfg_reg) begin
      calm_reg <= 3'h0;
    end else if (calm_reg != 3'h7) begin
      calm_reg <= calm_reg + 3'h1;
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);
  sequence settled;
    quiet;
  endsequence
  pull_drive_excl_a: assert property (~|(o_pullup_en & o_pin_oe))
    else $error("pull-up on while pin driven");
  route_off_a: assert property (quiet && !i_route_b.routing_global_enable |-> o_pin_oe == 21'h0 && o_pin_routed == 21'h0)
    else $error("pins active while routing off");
  skip_free_a: assert property (settled |-> (o_pin_routed & i_pin_cfg.pin_skip_mask & ~21'h000030) == 21'h0)
    else $error("skipped pin routed");
  small_pkg_a: assert property (quiet && !i_package_24pin |-> o_pin_routed[20:16] == 5'h00)
    else $error("port 2 routed on small package");
  uart_fixed_a: assert property (quiet && i_route_a.uart && i_route_b.routing_global_enable |-> o_pin_routed[5:4] == 2'h3)
    else $error("uart pins not routed");
  analog_off_a: assert property (settled |-> ((o_pin_oe | o_pullup_en) & ~i_pin_cfg.pin_input_mode) == 21'h0)
    else $error("analog pin driven or pulled");
  pullup_dis_a: assert property (quiet && i_route_b.pullup_disable |-> o_pullup_en == 21'h0)
    else $error("pull-up on while disabled");
  od_low_a: assert property (settled |-> (o_pin_out & ~i_pin_cfg.pin_output_mode) == 21'h0)
    else $error("open-drain pin drives high");
  reset_val_a: assert property ($rose(i_rstn) |-> o_pin_oe == 21'h0 && o_periph_in == 17'h1ffff)
    else $error("outputs not at reset value");
endmodule : pcx_port_crossbar_assertions

bind pcx_port_crossbar pcx_port_crossbar_assertions i_pcx_port_crossbar_assertions (
  .i_clock, .i_rstn, .i_route_a, .i_route_b, .i_spi_four_wire, .i_package_24pin, .i_pin_cfg,
  .i_gpio_latch, .i_periph_drive, .i_pin_in, .o_pin_out, .o_pin_oe, .o_pullup_en, .o_pin_level,
  .o_pin_routed, .o_periph_in
);

// ==== pcx_pad_model.sv ====
// Purpose: Board-side pads seen by the crossbar.
// Assumes: Bench supplies an external driver per pin.
// Notes: Floating pins toggle so no stale level survives.
`timescale 1ns/1ps
module pcx_pad_model (
  input wire logic i_clock,
  input wire logic [pcx_pkg::PIN_COUNT-1:0] i_pin_out,
  input wire logic [pcx_pkg::PIN_COUNT-1:0] i_pin_oe,
  input wire logic [pcx_pkg::PIN_COUNT-1:0] i_pullup_en,
  input wire logic [pcx_pkg::PIN_COUNT-1:0] i_ext_val,
  input wire logic [pcx_pkg::PIN_COUNT-1:0] i_ext_en,
  output logic [pcx_pkg::PIN_COUNT-1:0] o_pad
);
  import pcx_pkg::*;
  logic [PIN_COUNT-1:0] flip_reg = 21'h15aa55; // Floating pattern
  // Floating level changes every cycle
  always_ff @(posedge i_clock) begin
    flip_reg <= ~flip_reg;
  end
  // Device driver wins, then board, then pull-up
  always_comb begin
    for (int k = 0; k < PIN_COUNT; k++) begin
      if (i_pin_oe[k]) begin
        o_pad[k] = i_pin_out[k];
      end else if (i_ext_en[k]) begin
        o_pad[k] = i_ext_val[k];
      end else if (i_pullup_en[k]) begin
        o_pad[k] = 1'b1;
      end else begin
        o_pad[k] = flip_reg[k];
      end
    end
  end
endmodule : pcx_pad_model

// ==== testbench.sv ====
// Purpose: Self-checking bench for the port crossbar.
// Assumes: Pad model closes the loop from pins back to inputs.
// Notes: Pin maps are probed with a walking low on the pads.
`timescale 1ns/1ps
module testbench;
  import pcx_pkg::*;
  typedef int pcx_map_t [0:16];
  logic i_clock, i_rstn, i_spi_four_wire, i_package_24pin;
  pcx_route_a_t i_route_a;
  pcx_route_b_t i_route_b;
  pcx_pin_cfg_t i_pin_cfg;
  pcx_periph_t i_periph_drive;
  logic [20:0] i_gpio_latch, i_pin_in, ext_val, ext_en;
  logic [20:0] o_pin_out, o_pin_oe, o_pullup_en, o_pin_level, o_pin_routed;
  logic [16:0] o_periph_in;
  int n_mismatch = 0;
  int checked = 0;
  pcx_port_crossbar i_pcx_port_crossbar (.i_clock, .i_rstn, .i_route_a, .i_route_b, .i_spi_four_wire,
    .i_package_24pin, .i_pin_cfg, .i_gpio_latch, .i_periph_drive, .i_pin_in, .o_pin_out, .o_pin_oe,
    .o_pullup_en, .o_pin_level, .o_pin_routed, .o_periph_in);
  pcx_pad_model i_pcx_pad_model (.i_clock, .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
    .i_pullup_en(o_pullup_en), .i_ext_val(ext_val), .i_ext_en(ext_en), .o_pad(i_pin_in));
  // 25 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  // Compare one pin-wide result
  task automatic cmp(string what, logic [20:0] exp, logic [20:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // Counts, verdict, end of run
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  // Wait edges, then let updates land
  task automatic wait_out(int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : wait_out
  // Whole config in one step; peripherals idle
  task automatic apply(logic [5:0] ra, logic [6:0] rb, logic [20:0] skip, logic [20:0] inm,
                       logic [20:0] outm, logic [20:0] latch, logic four, logic pkg);
    i_route_a <= ra;
    i_route_b <= rb;
    i_pin_cfg <= {skip, inm, outm};
    i_gpio_latch <= latch;
    i_spi_four_wire <= four;
    i_package_24pin <= pkg;
    i_periph_drive <= 34'h0;
    ext_val <= 21'h1fffff;
    ext_en <= 21'h1fffff;
  endtask : apply
  // Expected pin per resource: uart fixed, rest lowest free pin
  function automatic pcx_map_t alloc(logic [16:0] want, logic [20:0] blk);
    pcx_map_t m;
    int r;
    r = 2;
    for (int k = 0; k < 17; k++) m[k] = -1;
    if (want[0]) begin
      m[0] = 4;
      m[1] = 5;
      blk[5:4] = 2'h3;
    end
    for (int p = 0; p < 21; p++) begin
      while (r < 17 && !want[r]) r++;
      if (!blk[p] && r < 17) begin
        m[r] = p;
        r++;
      end
    end
    return m;
  endfunction : alloc
  // Walk a low level over the pads, check each resource input
  task automatic check_map(logic [16:0] want, logic [20:0] blk);
    pcx_map_t m;
    logic [20:0] exp_route;
    logic [16:0] exp_in;
    m = alloc(want, blk);
    exp_route = 21'h0;
    for (int r = 0; r < 17; r++) if (m[r] >= 0) exp_route[m[r]] = 1'b1;
    cmp("routed", exp_route, o_pin_routed);
    for (int j = 0; j < 21; j++) begin
      @(posedge i_clock);
      ext_val <= ~(21'h1 << j);
      wait_out(6);
      for (int r = 0; r < 17; r++) exp_in[r] = !(m[r] == j);
      cmp("periph_in", {4'h0, exp_in}, {4'h0, o_periph_in});
    end
  endtask : check_map
  // Reset state of pins
  task automatic t_reset();
    cmp("pullup", 21'h1fffff, o_pullup_en);
    cmp("oe", 21'h0, o_pin_oe);
    cmp("periph_in", 21'h1ffff, {4'h0, o_periph_in});
    $display("test reset done");
  endtask : t_reset
  // Uart, two-wire, channel 0 with crystal pins skipped
  task automatic t_example();
    @(posedge i_clock);
    apply(6'h05, 7'h21, 21'h00000c, 21'h1fffff, 21'h0, 21'h1fffff, 1'b1, 1'b1);
    wait_out(6);
    cmp("routed", 21'h000073, o_pin_routed);
    check_map(17'h008c3, 21'h10000c);
    @(posedge i_clock);
    i_pin_cfg <= {21'h00000c, 21'h1fffff, 21'h1fffff};
    i_periph_drive <= {17'h00041, 17'h00041};
    wait_out(4);
    cmp("oe", 21'h1fff9c, o_pin_oe);
    cmp("out", 21'h1fff9c, o_pin_out);
    @(posedge i_clock);
    i_periph_drive <= {17'h00001, 17'h00041};
    wait_out(3);
    cmp("oe", 21'h1fff9d, o_pin_oe);
    $display("test example done");
  endtask : t_example
  // Everything on: 4-wire, 3-wire, small package; then counter channels 0 and 1 alone
  task automatic t_priority();
    @(posedge i_clock);
    apply(6'h3f, 7'h3f, 21'h0, 21'h1fffff, 21'h0, 21'h1fffff, 1'b1, 1'b1);
    wait_out(6);
    check_map(17'h1ffff, 21'h100000);
    @(posedge i_clock);
    apply(6'h3f, 7'h3f, 21'h0, 21'h1fffff, 21'h0, 21'h1fffff, 1'b0, 1'b1);
    wait_out(6);
    check_map(17'h1ffdf, 21'h100000);
    @(posedge i_clock);
    apply(6'h3f, 7'h3f, 21'h0, 21'h1fffff, 21'h0, 21'h1fffff, 1'b1, 1'b0);
    wait_out(6);
    check_map(17'h1ffff, 21'h1f0000);
    @(posedge i_clock);
    apply(6'h00, 7'h22, 21'h0, 21'h1fffff, 21'h0, 21'h1fffff, 1'b1, 1'b1);
    wait_out(6);
    check_map(17'h01800, 21'h100000);
    $display("test priority done");
  endtask : t_priority
  // Routing off with all resources and push-pull lows
  task automatic t_off();
    @(posedge i_clock);
    apply(6'h3f, 7'h1f, 21'h0, 21'h1fffff, 21'h1fffff, 21'h0, 1'b1, 1'b1);
    wait_out(6);
    cmp("oe", 21'h0, o_pin_oe);
    check_map(17'h0, 21'h100000);
    $display("test off done");
  endtask : t_off
  // Analog pin 3, open-drain low on pin 2, then pull-ups off
  task automatic t_pins();
    @(posedge i_clock);
    apply(6'h00, 7'h20, 21'h00000c, 21'h1ffff7, 21'h000008, 21'h1ffffb, 1'b1, 1'b1);
    wait_out(7);
    cmp("oe", 21'h000004, o_pin_oe);
    cmp("pullup", 21'h1ffff3, o_pullup_en);
    cmp("level", 21'h1ffff3, o_pin_level);
    @(posedge i_clock);
    i_route_b <= 7'h60;
    wait_out(4);
    cmp("pullup", 21'h0, o_pullup_en);
    $display("test pins done");
  endtask : t_pins
  // Main sequence
  initial begin
    i_rstn <= 1'b0;
    apply(6'h00, 7'h00, 21'h0, 21'h1fffff, 21'h0, 21'h1fffff, 1'b1, 1'b1);
    repeat (3) @(posedge i_clock);
    i_rstn <= 1'b1;
    wait_out(4);
    t_reset();
    t_example();
    t_priority();
    t_off();
    t_pins();
    conclude();
  end
  // Watchdog: tests need about 1000 cycles
  initial begin
    repeat (20000) @(posedge i_clock);
    n_mismatch++;
    conclude();
  end
endmodule : testbench
